// File: inc/fgp_cfg.svh
// Constants for the fast GPIO port with pin multiplexer
`ifndef FGP_CFG_SVH
`define FGP_CFG_SVH
`define FGP_PINS 12
`define FGP_FSEL_W 3
`define FGP_PULL_W 2
`define FGP_I2C_PIN_A 4
`define FGP_I2C_PIN_B 5
`define FGP_WIN_LSB 14
`define FGP_WIN_BASE 18'h0_2000
`define FGP_OFF_DATA 14'h0000
`define FGP_OFF_DIR 14'h0004
`define FGP_OFF_SET 14'h0008
`define FGP_OFF_CLR 14'h000C
`define FGP_OFF_SENSE 14'h0010
`define FGP_OFF_BOTH 14'h0014
`define FGP_OFF_EVENT 14'h0018
`define FGP_OFF_IEN 14'h001C
`define FGP_OFF_RAW 14'h0020
`define FGP_OFF_ICLR 14'h0024
`define FGP_OFF_MASKED 14'h0028
`define FGP_OFF_CFG0 14'h0100
`define FGP_CFG_IDX_LSB 2
`define FGP_CFG_IDX_W 4
`define FGP_FSEL_LSB 0
`define FGP_PULL_LSB 3
`define FGP_FSEL_GPIO 3'h0
`define FGP_PULL_NONE 2'h0
`define FGP_PULL_UP 2'h1
`define FGP_PULL_DOWN 2'h2
`define FGP_NFUNC 4
`endif

// File: inc/fgp_pkg.sv
// Types for the fast GPIO port with pin multiplexer
`include "fgp_cfg.svh"
package fgp_pkg;
  typedef logic [`FGP_PINS-1:0] fgp_vec_t;
  typedef struct packed {
    logic valid;
    logic write;
    logic [31:0] addr;
    logic [31:0] wdata;
  } fgp_acc_s;
  typedef struct packed {
    logic [`FGP_PULL_W-1:0] pull;
    logic [`FGP_FSEL_W-1:0] fsel;
  } fgp_pin_cfg_s;
  typedef struct packed {
    fgp_vec_t sense;
    fgp_vec_t both;
    fgp_vec_t event_hi;
    fgp_vec_t enable;
  } fgp_irq_cfg_s;
endpackage

// File: sim/fgp_pad_model.sv
// Pad and external driver model for the port's pins
`timescale 1ns/1ps
`default_nettype none
`include "fgp_cfg.svh"
module fgp_pad_model (
  input wire logic ref_clk,
  input wire fgp_pkg::fgp_vec_t pin_out,
  input wire fgp_pkg::fgp_vec_t pin_oe_b,
  input wire fgp_pkg::fgp_vec_t pull_up_en,
  input wire fgp_pkg::fgp_vec_t pull_down_en,
  input wire fgp_pkg::fgp_vec_t ext_val,
  input wire fgp_pkg::fgp_vec_t ext_en,
  output var fgp_pkg::fgp_vec_t pad
);
  import fgp_pkg::*;
  fgp_vec_t drift = 12'h0a5a;
  // A floating pad must not settle on a lucky value
  always @(posedge ref_clk) begin
    drift <= ~drift;
  end
  // Port drive wins, then the outside driver, then the pulls
  always_comb begin
    for (int i = 0; i < `FGP_PINS; i++) begin
      if (!pin_oe_b[i]) pad[i] = pin_out[i];
      else if (ext_en[i]) pad[i] = ext_val[i];
      else if (pull_up_en[i]) pad[i] = 1'b1;
      else if (pull_down_en[i]) pad[i] = 1'b0;
      else pad[i] = drift[i];
    end
  end
endmodule
`default_nettype wire

// File: sim/fgp_port_chk.sv
// Assertion checker for the fast GPIO port
`timescale 1ns/1ps
`default_nettype none
`include "fgp_cfg.svh"
module fgp_port_chk (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire fgp_pkg::fgp_acc_s acc,
  input wire logic rd_valid,
  input wire fgp_pkg::fgp_vec_t pin_out,
  input wire fgp_pkg::fgp_vec_t pin_oe_b,
  input wire fgp_pkg::fgp_vec_t pull_up_en,
  input wire logic irq
);
  import fgp_pkg::*;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  logic hit, wr, muxed;
  logic [13:0] off;
  fgp_vec_t ien, sense;
  // Window decode seen from the bus side
  assign hit = acc.valid && acc.addr[31:14] == `FGP_WIN_BASE;
  assign wr = hit && acc.write;
  assign off = acc.addr[13:0];
  // Shadows of mask and mode; muxed stops output checks once a function owns a pin
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      ien <= '0;
      sense <= '0;
      muxed <= 1'b0;
    end else if (wr) begin
      if (off == `FGP_OFF_IEN) ien <= acc.wdata[11:0];
      if (off == `FGP_OFF_SENSE) sense <= acc.wdata[11:0];
      if (off >= `FGP_OFF_CFG0 && acc.wdata[2:0] != `FGP_FSEL_GPIO) muxed <= 1'b1;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  property p_rd_lat;
    hit && !acc.write |=> rd_valid;
  endproperty
  a_rd_lat: assert property (p_rd_lat) else $error("read not answered");
  property p_rd_none;
    !(hit && !acc.write) |=> !rd_valid;
  endproperty
  a_rd_none: assert property (p_rd_none) else $error("answer without read");
  property p_data;
    // Latch moves at the taking edge, the pad flop one edge later
    wr && off == `FGP_OFF_DATA && !muxed |-> ##2 pin_out == $past(acc.wdata[11:0], 2);
  endproperty
  a_data: assert property (p_data) else $error("port write not whole");
  property p_set;
    wr && off == `FGP_OFF_SET && !muxed |-> ##2
      pin_out == ($past(pin_out) | $past(acc.wdata[11:0], 2));
  endproperty
  a_set: assert property (p_set) else $error("set touched other bits");
  property p_dir;
    wr && off == `FGP_OFF_DIR && !muxed |-> ##2 pin_oe_b == ~$past(acc.wdata[11:0], 2);
  endproperty
  a_dir: assert property (p_dir) else $error("direction not applied");
  property p_reset;
    $rose(rst_b) |-> pin_oe_b == 12'hfff && pull_up_en == 12'h0fcf && !irq;
  endproperty
  a_reset: assert property (p_reset) else $error("bad pad state after reset");
  property p_mask;
    ien == '0 |=> !irq;
  endproperty
  a_mask: assert property (p_mask) else $error("irq with all masked");
  property p_latch;
    sense == '0 && irq && !wr && !$past(wr) |=> irq;
  endproperty
  a_latch: assert property (p_latch) else $error("edge irq dropped");
endmodule
bind fgp_port fgp_port_chk u_chk (.ref_clk, .rst_b, .acc, .rd_valid, .pin_out, .pin_oe_b,
  .pull_up_en, .irq);
`default_nettype wire

// File: sim/tb_top.sv
// Self-checking bench for the fast GPIO port
`timescale 1ns/1ps
`default_nettype none
`include "fgp_cfg.svh"
module tb_top;
  import fgp_pkg::*;
  localparam logic [31:0] BASE = {`FGP_WIN_BASE, 14'h0000};
  logic ref_clk, rst_b, rd_valid, irq;
  logic [31:0] rd_data;
  fgp_acc_s acc;
  fgp_vec_t pin_in, pin_out, pin_oe_b, pull_up_en, pull_down_en, periph_in, ext_val, ext_en;
  fgp_vec_t d, v, s, c, b;
  logic [`FGP_NFUNC*`FGP_PINS-1:0] periph_out, periph_oe;
  int n_fail, check_count, i, f;
  fgp_port uut (.ref_clk, .rst_b, .acc, .rd_data, .rd_valid, .pin_in, .pin_out, .pin_oe_b,
    .pull_up_en, .pull_down_en, .periph_out, .periph_oe, .periph_in, .irq);
  fgp_pad_model u_pad (.ref_clk, .pin_out, .pin_oe_b, .pull_up_en, .pull_down_en, .ext_val,
    .ext_en, .pad(pin_in));
  ////////////////////////////////////////////////////////////////////////////
  // Clock and hang guard
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  initial begin
    #200000;
    n_fail++;
    summarize();
  end
  // Expected output latch after set and clear
  function automatic fgp_vec_t upd(fgp_vec_t o, fgp_vec_t st, fgp_vec_t cl);
    return (o | st) & ~cl;
  endfunction
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  // Single-cycle bus requests, launched on the falling edge
  task automatic wr(input logic [13:0] o, input logic [31:0] dat);
    @(negedge ref_clk);
    acc = '{1'b1, 1'b1, BASE | o, dat};
    @(negedge ref_clk);
    acc.valid = 1'b0;
  endtask
  task automatic rd(input logic [31:0] a, input logic [31:0] e);
    @(negedge ref_clk);
    acc = '{1'b1, 1'b0, a, 32'h0000_0000};
    // Answer stands for the one cycle after the taking edge only
    @(negedge ref_clk);
    chk("rd_valid", a[31:14] == `FGP_WIN_BASE, rd_valid);
    chk("rd_data", e, rd_data);
    acc.valid = 1'b0;
  endtask
  task automatic summarize();
    $display("checks %0d failures %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    acc = '0;
    ext_val = '0;
    ext_en = '0;
    periph_out = '0;
    periph_oe = '0;
    n_fail = 0;
    check_count = 0;
    rst_b = 1'b0;
    void'($urandom(32'h0ff82adb));
    tick(10);
    rst_b = 1'b1;
    chk("oe_b", 12'hfff, pin_oe_b);
    chk("pull_up", 12'h0fcf, pull_up_en);
    // Direction, whole-port write, set and clear with random masks
    for (int k = 0; k < 5; k++) begin
      d = 12'($urandom);
      v = 12'($urandom);
      s = 12'($urandom);
      c = 12'($urandom);
      wr(`FGP_OFF_DIR, d);
      tick(1);
      chk("oe_b", fgp_vec_t'(~d), pin_oe_b);
      wr(`FGP_OFF_DATA, v);
      tick(1);
      chk("pin_out", v, pin_out);
      wr(`FGP_OFF_SET, s);
      wr(`FGP_OFF_CLR, c);
      rd(BASE | `FGP_OFF_SET, upd(v, s, 12'h000) & ~c);
    end
    // Sampling of undriven pins, unmapped and outside addresses
    wr(`FGP_OFF_DIR, 0);
    ext_en = '1;
    ext_val = v;
    tick(3);
    chk("periph_in", v, periph_in);
    rd(BASE, v);
    rd(BASE | 32'h0000_0030, 0);
    rd(BASE + 32'h0000_4000, 0);
    // Pull selection per pin, I2C pins have none
    for (int k = 0; k < `FGP_PINS; k++) begin
      wr(14'(`FGP_OFF_CFG0 + 4 * k), {`FGP_PULL_DOWN, `FGP_FSEL_GPIO});
      tick(1);
      chk("pull_dn", k != `FGP_I2C_PIN_A && k != `FGP_I2C_PIN_B, pull_down_en[k]);
    end
    // Every trigger mode on a random pin: level, rise, fall, both
    ext_val = '0;
    for (int m = 0; m < 4; m++) begin
      b = 12'h001 << $urandom_range(11, 0);
      wr(`FGP_OFF_IEN, b);
      wr(`FGP_OFF_SENSE, m == 0 ? b : 12'h000);
      wr(`FGP_OFF_BOTH, m == 3 ? b : 12'h000);
      wr(`FGP_OFF_EVENT, m != 2 ? b : 12'h000);
      wr(`FGP_OFF_ICLR, b);
      tick(4);
      chk("irq_idle", 0, irq);
      ext_val = b;
      tick(4);
      chk("irq_hi", m != 2, irq);
      ext_val = '0;
      tick(4);
      chk("irq_lo", m != 0, irq);
      wr(`FGP_OFF_IEN, 0);
      tick(2);
      chk("irq_mask", 0, irq);
      wr(`FGP_OFF_IEN, b);
      tick(2);
      chk("irq_unmask", m != 0, irq);
      wr(`FGP_OFF_ICLR, b);
      tick(4);
      chk("irq_clr", 0, irq);
    end
    // Function routing, code 4 leaves the pin undriven
    periph_out = 48'({$urandom, $urandom});
    periph_oe = 48'({$urandom, $urandom});
    for (int k = 0; k < 8; k++) begin
      i = $urandom_range(11, 0);
      f = $urandom_range(4, 1);
      // Pin is mapped before its function's drive is looked at
      wr(14'(`FGP_OFF_CFG0 + 4 * i), {`FGP_PULL_NONE, 3'(f)});
      tick(1);
      chk("mux_oe_b", f == 4 ? 1'b1 : !periph_oe[f * 12 + i], pin_oe_b[i]);
      if (f != 4 && periph_oe[f * 12 + i]) chk("mux_out", periph_out[f * 12 + i], pin_out[i]);
    end
    summarize();
  end
endmodule
`default_nettype wire

// File: verilog/fgp_pin_irq.sv
// Per-pin interrupt detector: level, rising, falling or both edges
`timescale 1ns/1ps
`default_nettype none
module fgp_pin_irq (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic pin_now,
  input wire logic pin_prev,
  input wire logic level_mode,
  input wire logic both_edges,
  input wire logic active_high,
  input wire logic clear,
  output logic flag
);
  logic rise;
  logic fall;
  logic edge_hit;
  logic edge_flag;

  // Edge qualifiers from the registered pin history
  assign rise = pin_now & ~pin_prev;
  assign fall = ~pin_now & pin_prev;
  assign edge_hit = both_edges ? (rise | fall) : (active_high ? rise : fall); // R5

  // Sticky edge flag; a new edge beats a clear in the same cycle
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      edge_flag <= 1'b0;
    end else if (!level_mode && edge_hit) begin
      edge_flag <= 1'b1; // R13
    end else if (clear || level_mode) begin
      edge_flag <= 1'b0;
    end
  end

  // Level mode follows the pin, no latching
  assign flag = level_mode ? (pin_now == active_high) : edge_flag; // R13
endmodule
`default_nettype wire

// File: verilog/fgp_port.sv
// Fast GPIO port with per-pin function multiplexer and pin interrupts
//
// Function
// R1 - Pins not given to a peripheral are driven and sampled through the port registers.
// R2 - Each pin's direction is a separate bit software may change at any time.
// R3 - One write to the set or clear register changes only the selected output bits.
// R4 - One write to the data register replaces the whole output value.
// R5 - Each pin can interrupt on level, rising edge, falling edge or both edges.
// R6 - A per-pin config register selects which on-chip function owns the pin.
// R7 - Software should map a peripheral to its pins before enabling it.
// R8 - All pin flags merge onto one interrupt request line.
// R9 - Registers are a dedicated fast slave with single-cycle access.
// R10 - The register window is a fixed 16 kB space decoded from the upper address bits.
// R11 - After reset every pin is an input with pull-up, except the two I2C pins.
// R12 - Config registers hold a pull selection for every pin except the two I2C pins.
// R13 - Edge interrupts latch until cleared; level interrupts follow the pin.
`timescale 1ns/1ps
`default_nettype none
`include "fgp_cfg.svh"
module fgp_port (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire fgp_pkg::fgp_acc_s acc,
  output logic [31:0] rd_data,
  output logic rd_valid,
  input wire fgp_pkg::fgp_vec_t pin_in,
  output fgp_pkg::fgp_vec_t pin_out,
  output fgp_pkg::fgp_vec_t pin_oe_b,
  output fgp_pkg::fgp_vec_t pull_up_en,
  output fgp_pkg::fgp_vec_t pull_down_en,
  input wire logic [`FGP_NFUNC*`FGP_PINS-1:0] periph_out,
  input wire logic [`FGP_NFUNC*`FGP_PINS-1:0] periph_oe,
  output fgp_pkg::fgp_vec_t periph_in,
  output logic irq
);
  import fgp_pkg::*;

  fgp_vec_t out_reg;
  fgp_vec_t dir_reg;
  fgp_vec_t pin_q;
  fgp_vec_t pin_prev;
  fgp_vec_t raw_flag;
  fgp_vec_t clr_pulse;
  fgp_irq_cfg_s icfg;
  fgp_pin_cfg_s pcfg [`FGP_PINS];
  logic hit;
  logic wr;
  logic [13:0] off;
  logic [`FGP_CFG_IDX_W-1:0] cfg_idx;
  logic cfg_hit;
  fgp_vec_t wvec;
  fgp_vec_t next_out;
  fgp_vec_t next_oe_b;
  logic [31:0] next_rd;

  //////////////////////////////////////////////////////////////////////////////
  // Address decode

  // Window is selected by the bits above the 16 kB boundary only
  assign hit = acc.valid && (acc.addr[31:`FGP_WIN_LSB] == `FGP_WIN_BASE); // R10
  assign wr = hit && acc.write; // R9
  assign off = acc.addr[`FGP_WIN_LSB-1:0];
  assign cfg_idx = off[`FGP_CFG_IDX_LSB +: `FGP_CFG_IDX_W];
  assign cfg_hit = (off[13:`FGP_CFG_IDX_LSB+`FGP_CFG_IDX_W] ==
                    `FGP_OFF_CFG0 >> (`FGP_CFG_IDX_LSB+`FGP_CFG_IDX_W))
                   && (cfg_idx < `FGP_CFG_IDX_W'(`FGP_PINS));
  assign wvec = acc.wdata[`FGP_PINS-1:0];

  //////////////////////////////////////////////////////////////////////////////
  // Port data and direction

  // Output latch: whole-port write, set and clear masks
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      out_reg <= '0;
    end else if (wr && off == `FGP_OFF_DATA) begin
      out_reg <= wvec; // R4
    end else if (wr && off == `FGP_OFF_SET) begin
      out_reg <= out_reg | wvec; // R3
    end else if (wr && off == `FGP_OFF_CLR) begin
      out_reg <= out_reg & ~wvec; // R3
    end
  end

  // Direction, one bit per pin, 1 means output; reset to all inputs
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      dir_reg <= '0; // R11
    end else if (wr && off == `FGP_OFF_DIR) begin
      dir_reg <= wvec; // R2
    end
  end

  // Pin sampling history, inputs are already synchronous
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      pin_q <= '0;
      pin_prev <= '0;
    end else begin
      pin_q <= pin_in; // R1
      pin_prev <= pin_q;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Pin configuration and multiplexer

  // Per-pin function select and pull; I2C pins keep no pull bits
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < `FGP_PINS; i++) begin
        pcfg[i].fsel <= `FGP_FSEL_GPIO;
        pcfg[i].pull <= (i == `FGP_I2C_PIN_A || i == `FGP_I2C_PIN_B) ?
                        `FGP_PULL_NONE : `FGP_PULL_UP; // R11
      end
    end else if (wr && cfg_hit) begin
      pcfg[cfg_idx].fsel <= acc.wdata[`FGP_FSEL_LSB +: `FGP_FSEL_W]; // R6
      if (cfg_idx != `FGP_CFG_IDX_W'(`FGP_I2C_PIN_A) &&
          cfg_idx != `FGP_CFG_IDX_W'(`FGP_I2C_PIN_B)) begin
        pcfg[cfg_idx].pull <= acc.wdata[`FGP_PULL_LSB +: `FGP_PULL_W]; // R12
      end
    end
  end

  // Mux: function 0 is the port, others come from peripherals; unknown codes float
  always_comb begin
    next_out = '0;
    next_oe_b = '1;
    for (int i = 0; i < `FGP_PINS; i++) begin
      if (pcfg[i].fsel == `FGP_FSEL_GPIO) begin
        next_out[i] = out_reg[i]; // R1
        next_oe_b[i] = ~dir_reg[i]; // R2
      end else if (32'(pcfg[i].fsel) < `FGP_NFUNC) begin
        next_out[i] = periph_out[32'(pcfg[i].fsel)*`FGP_PINS + i]; // R6
        next_oe_b[i] = ~periph_oe[32'(pcfg[i].fsel)*`FGP_PINS + i];
      end
    end
  end

  // Registered pad drive so every output comes from a flop
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      pin_out <= '0;
      pin_oe_b <= '1;
      for (int i = 0; i < `FGP_PINS; i++) begin
        pull_up_en[i] <= !(i == `FGP_I2C_PIN_A || i == `FGP_I2C_PIN_B); // R11
      end
      pull_down_en <= '0;
      periph_in <= '0;
    end else begin
      pin_out <= next_out;
      pin_oe_b <= next_oe_b;
      periph_in <= pin_q; // Peripherals see every pin, mapped or not (R7 is software's)
      for (int i = 0; i < `FGP_PINS; i++) begin
        pull_up_en[i] <= (pcfg[i].pull == `FGP_PULL_UP); // R12
        pull_down_en[i] <= (pcfg[i].pull == `FGP_PULL_DOWN);
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Interrupts

  // Interrupt configuration; reset leaves every source disabled
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      icfg <= '0;
    end else if (wr) begin
      if (off == `FGP_OFF_SENSE) icfg.sense <= wvec; // R5
      if (off == `FGP_OFF_BOTH) icfg.both <= wvec;
      if (off == `FGP_OFF_EVENT) icfg.event_hi <= wvec;
      if (off == `FGP_OFF_IEN) icfg.enable <= wvec;
    end
  end

  assign clr_pulse = (wr && off == `FGP_OFF_ICLR) ? wvec : '0;

  // Detectors work on any pin regardless of its function
  for (genvar g = 0; g < `FGP_PINS; g++) begin : g_irq
    fgp_pin_irq u_det (
      .ref_clk(ref_clk),
      .rst_b(rst_b),
      .pin_now(pin_q[g]),
      .pin_prev(pin_prev[g]),
      .level_mode(icfg.sense[g]),
      .both_edges(icfg.both[g]),
      .active_high(icfg.event_hi[g]),
      .clear(clr_pulse[g]),
      .flag(raw_flag[g])
    );
  end

  // Single request line to the interrupt controller
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      irq <= 1'b0;
    end else begin
      irq <= |(raw_flag & icfg.enable); // R8
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Read path

  // Unmapped offsets read as zero; data reads the pins, not the latch
  always_comb begin
    next_rd = '0;
    if (cfg_hit) begin
      next_rd[`FGP_FSEL_LSB +: `FGP_FSEL_W] = pcfg[cfg_idx].fsel;
      next_rd[`FGP_PULL_LSB +: `FGP_PULL_W] = pcfg[cfg_idx].pull;
    end else begin
      unique case (off)
        `FGP_OFF_DATA: next_rd[`FGP_PINS-1:0] = pin_q; // R1
        `FGP_OFF_SET: next_rd[`FGP_PINS-1:0] = out_reg;
        `FGP_OFF_DIR: next_rd[`FGP_PINS-1:0] = dir_reg;
        `FGP_OFF_SENSE: next_rd[`FGP_PINS-1:0] = icfg.sense;
        `FGP_OFF_BOTH: next_rd[`FGP_PINS-1:0] = icfg.both;
        `FGP_OFF_EVENT: next_rd[`FGP_PINS-1:0] = icfg.event_hi;
        `FGP_OFF_IEN: next_rd[`FGP_PINS-1:0] = icfg.enable;
        `FGP_OFF_RAW: next_rd[`FGP_PINS-1:0] = raw_flag;
        `FGP_OFF_MASKED: next_rd[`FGP_PINS-1:0] = raw_flag & icfg.enable;
        default: next_rd = '0;
      endcase
    end
  end

  // One-cycle read answer
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rd_data <= '0;
      rd_valid <= 1'b0;
    end else begin
      rd_valid <= hit && !acc.write; // R9
      rd_data <= (hit && !acc.write) ? next_rd : '0;
    end
  end
endmodule
`default_nettype wire
